// *** rtl/metering_regs_map.svh ***
/*
 * Offsets, reset values, keys and checksum constants of the metering
 * configuration and status register bank.
 * Assumes the serial register port engine presents word addresses as
 * printed offsets and 16-bit write data.
 */
// Overview of operation
// - Any set bit in the autocal tier-2 flags raises its summary bit in the tier-1 status.
// - Reading the autocal tier-2 flags returns them and clears every bit except those set by an event on the read's clock.
// - An event that lands on the clock of a clearing read stays set after the read.
// - The power-quality tier-2 flags summarise and clear on read exactly like the autocal flags.
// - The chip-error tier-2 flags summarise and clear on read exactly like the autocal flags.
// - Writing 0x0052 to the rate select selects 115200 baud, any other value selects 4800 baud.
// - Writing the checksum trigger starts an immediate checksum pass over the configuration registers.
// - The lock register engages a lock that blocks writes to the configuration registers.
// - The burst registers from 0x600 return the live measurement values they mirror.
// - The power and energy update time registers reset to 0x00ff.
`ifndef METERING_REGS_MAP_SVH
`define METERING_REGS_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_ENERGY_POWER_ACCUM_CONFIG 12'h4b0
`define ADDR_POWER_UPDATE_TIME 12'h4b1
`define ADDR_ENERGY_UPDATE_TIME 12'h4b2
`define ADDR_CHECKSUM_TRIGGER 12'h4b4
`define ADDR_TEMP_SENSOR_CONFIG 12'h4b6
`define ADDR_TEMP_MEASURE_RESULT 12'h4b7
`define ADDR_CURRENT_A_GAIN 12'h4b9
`define ADDR_CONFIG_LOCK 12'h4bf
`define ADDR_AUTOCAL_FLAGS 12'h4c0
`define ADDR_PQ_FLAGS 12'h4c1
`define ADDR_CHIP_ERR_FLAGS 12'h4c2
`define ADDR_SERIAL_RATE 12'h4dc
`define ADDR_SILICON_REV 12'h4fe
`define ADDR_BURST_AI_WAVE 12'h600
`define ADDR_BURST_AV_WAVE 12'h601
`define ADDR_BURST_BI_WAVE 12'h602
`define ADDR_BURST_AI_RMS 12'h604
`define ADDR_BURST_BI_RMS 12'h605

// ****************************************
// Reset values and keys
// ****************************************
`define RST_ZERO16 16'h0000
`define RST_UPDATE_TIME 16'h00ff
`define RST_ZERO32 32'h0000_0000
`define FAST_BAUD_KEY 16'h0052
`define LOCK_ENGAGE_BIT 0

// ****************************************
// Checksum pass
// ****************************************
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff
`define CRC_WORDS 3'h5
`define CRC_LAST_IDX 3'h4

`endif

// *** rtl/metering_regs_pkg.sv ***
/*
 * Types shared by the metering register bank.
 * Assumes the map header is included alongside.
 */
package metering_regs_pkg;

    typedef logic [15:0] reg16_t;

    typedef enum logic [1:0] {
        CRC_IDLE,
        CRC_RUN,
        CRC_DONE
    } crc_state_t;

endpackage : metering_regs_pkg

// *** rtl/tier2_status_reg.sv ***
/*
 * One clear-on-read tier-2 status register with its summary bit.
 * Assumes events and read strobe come from logic on i_mclk.
 */
`timescale 1ns/1ps
`include "metering_regs_map.svh"
module tier2_status_reg #(
    parameter int WIDTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_rd_clear,
    output logic [WIDTH-1:0] o_flags,
    output logic o_any
);

    logic [WIDTH-1:0] flags_r;

    // ****************************************
    // Sticky flags, set wins over clear
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            flags_r <= '0;
        end else if (i_rd_clear) begin
            flags_r <= i_set;
        end else begin
            flags_r <= flags_r | i_set;
        end
    end

    assign o_flags = flags_r;
    assign o_any = |flags_r;

    AST_EVENT_SURVIVES_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_rd_clear && (|i_set)) |=> ((flags_r & $past(i_set)) == $past(i_set)))
        else $error("Event lost on clearing read");

    AST_SUMMARY_FOLLOWS: assert property (@(posedge i_mclk) disable iff (i_rst)
        (|i_set) |=> o_any)
        else $error("Summary bit missing after event");

endmodule : tier2_status_reg

// *** rtl/metering_config_status_regs.sv ***
/*
 * Upper configuration and status register bank of the metering core:
 * accumulation timing, temperature and gain setup, configuration lock,
 * checksum pass, tier-2 status flags, serial rate select, burst mirrors.
 * Assumes a serial port engine on i_mclk issuing one-cycle read and write
 * strobes with a word address; measurement values are on i_mclk too.
 */
`timescale 1ns/1ps
`include "metering_regs_map.svh"
module metering_config_status_regs import metering_regs_pkg::*; #(
    parameter int CRC_REFRESH_CYCLES = 1024,
    parameter logic [15:0] SILICON_REV = 16'h0a5c // Arbitrary value
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_autocal_evt,
    input wire logic [15:0] i_pq_evt,
    input wire logic [15:0] i_chip_evt,
    input wire logic [15:0] i_temp_result,
    input wire logic [31:0] i_meas_ai_wave,
    input wire logic [31:0] i_meas_av_wave,
    input wire logic [31:0] i_meas_bi_wave,
    input wire logic [31:0] i_meas_ai_rms,
    input wire logic [31:0] i_meas_bi_rms,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic [15:0] o_energy_power_accum_config,
    output logic [15:0] o_power_update_time,
    output logic [15:0] o_energy_update_time,
    output logic [15:0] o_temp_sensor_config,
    output logic [15:0] o_current_a_gain_select,
    output logic o_config_locked,
    output logic [2:0] o_tier1_summary,
    output logic o_fast_baud,
    output logic [15:0] o_crc_result,
    output logic o_crc_busy,
    output logic o_crc_done
);

    // ****************************************
    // Decode
    // ****************************************
    reg16_t energy_power_accum_config_r;
    reg16_t power_update_time_r;
    reg16_t energy_update_time_r;
    reg16_t temp_cfg_r;
    reg16_t ai_gain_r;
    reg16_t lock_r;
    logic fast_baud_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic cfg_wr;
    logic force_wr;
    logic rd_autocal;
    logic rd_pq;
    logic rd_chip;
    logic [15:0] autocal_flags;
    logic [15:0] pq_flags;
    logic [15:0] chip_flags;
    logic [2:0] summary;

    // Lock register itself stays writable so software can release it
    assign o_config_locked = lock_r[`LOCK_ENGAGE_BIT];
    assign cfg_wr = i_wr && !o_config_locked;
    assign force_wr = i_wr && (i_addr == `ADDR_CHECKSUM_TRIGGER);
    assign rd_autocal = i_rd && (i_addr == `ADDR_AUTOCAL_FLAGS);
    assign rd_pq = i_rd && (i_addr == `ADDR_PQ_FLAGS);
    assign rd_chip = i_rd && (i_addr == `ADDR_CHIP_ERR_FLAGS);

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            energy_power_accum_config_r <= `RST_ZERO16;
            power_update_time_r <= `RST_UPDATE_TIME;
            energy_update_time_r <= `RST_UPDATE_TIME;
            temp_cfg_r <= `RST_ZERO16;
            ai_gain_r <= `RST_ZERO16;
        end else if (cfg_wr) begin
            // Read-only offsets fall through untouched
            case (i_addr)
                `ADDR_ENERGY_POWER_ACCUM_CONFIG: begin
                    energy_power_accum_config_r <= i_wdata;
                end
                `ADDR_POWER_UPDATE_TIME: begin
                    power_update_time_r <= i_wdata;
                end
                `ADDR_ENERGY_UPDATE_TIME: begin
                    energy_update_time_r <= i_wdata;
                end
                `ADDR_TEMP_SENSOR_CONFIG: begin
                    temp_cfg_r <= i_wdata;
                end
                `ADDR_CURRENT_A_GAIN: begin
                    ai_gain_r <= i_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            lock_r <= `RST_ZERO16;
        end else if (i_wr && (i_addr == `ADDR_CONFIG_LOCK)) begin
            lock_r <= i_wdata;
        end
    end

    // ****************************************
    // Serial rate select
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            fast_baud_r <= 1'b0;
        end else if (i_wr && (i_addr == `ADDR_SERIAL_RATE)) begin
            fast_baud_r <= (i_wdata == `FAST_BAUD_KEY);
        end
    end

    assign o_energy_power_accum_config = energy_power_accum_config_r;
    assign o_power_update_time = power_update_time_r;
    assign o_energy_update_time = energy_update_time_r;
    assign o_temp_sensor_config = temp_cfg_r;
    assign o_current_a_gain_select = ai_gain_r;
    assign o_fast_baud = fast_baud_r;

    // ****************************************
    // Tier-2 status flags
    // ****************************************
    tier2_status_reg #(.WIDTH(16)) u_autocal_flags (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(i_autocal_evt),
        .i_rd_clear(rd_autocal),
        .o_flags(autocal_flags),
        .o_any(summary[0])
    );

    tier2_status_reg #(.WIDTH(16)) u_pq_flags (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(i_pq_evt),
        .i_rd_clear(rd_pq),
        .o_flags(pq_flags),
        .o_any(summary[1])
    );

    tier2_status_reg #(.WIDTH(16)) u_chip_flags (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(i_chip_evt),
        .i_rd_clear(rd_chip),
        .o_flags(chip_flags),
        .o_any(summary[2])
    );

    assign o_tier1_summary = summary;

    // ****************************************
    // Checksum pass over configuration words
    // ****************************************
    crc_state_t crc_state_r;
    logic [2:0] crc_idx_r;
    logic [15:0] crc_acc_r;
    logic [15:0] crc_result_r;
    logic [31:0] refresh_cnt_r;
    logic refresh_due;
    logic crc_start;
    logic [15:0] crc_word;
    logic [15:0] crc_step;

    function automatic logic [15:0] crc16_word(input logic [15:0] acc, input logic [15:0] data);
        logic [15:0] c;
        logic fb;
        c = acc;
        for (int b = 15; b >= 0; b--) begin
            fb = c[15] ^ data[b];
            c = {c[14:0], 1'b0};
            if (fb) begin
                c = c ^ `CRC_POLY;
            end
        end
        return c;
    endfunction : crc16_word

    // Periodic refresh keeps the result current without host action
    assign refresh_due = (refresh_cnt_r == 32'(CRC_REFRESH_CYCLES - 1));

    always_ff @(posedge i_mclk) begin
        if (i_rst || refresh_due) begin
            refresh_cnt_r <= 32'h0000_0000;
        end else begin
            refresh_cnt_r <= refresh_cnt_r + 32'h0000_0001;
        end
    end

    assign crc_start = force_wr || refresh_due;

    always_comb begin
        case (crc_idx_r)
            3'h0: crc_word = energy_power_accum_config_r;
            3'h1: crc_word = power_update_time_r;
            3'h2: crc_word = energy_update_time_r;
            3'h3: crc_word = temp_cfg_r;
            default: crc_word = ai_gain_r;
        endcase
    end

    assign crc_step = crc16_word(crc_acc_r, crc_word);

    // A new start mid-pass restarts it; a configuration write mid-pass does not, so the result can mix old and new words
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            crc_state_r <= CRC_IDLE;
            crc_idx_r <= 3'h0;
            crc_acc_r <= `CRC_INIT;
        end else if (crc_start) begin
            crc_state_r <= CRC_RUN;
            crc_idx_r <= 3'h0;
            crc_acc_r <= `CRC_INIT;
        end else begin
            case (crc_state_r)
                CRC_RUN: begin
                    crc_acc_r <= crc_step;
                    crc_idx_r <= crc_idx_r + 3'h1;
                    if (crc_idx_r == `CRC_LAST_IDX) begin
                        crc_state_r <= CRC_DONE;
                    end
                end
                CRC_DONE: begin
                    crc_state_r <= CRC_IDLE;
                end
                default: begin
                    crc_state_r <= CRC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            crc_result_r <= `RST_ZERO16;
        end else if (!crc_start && crc_state_r == CRC_RUN && crc_idx_r == `CRC_LAST_IDX) begin
            crc_result_r <= crc_step;
        end
    end

    assign o_crc_result = crc_result_r;
    assign o_crc_busy = (crc_state_r != CRC_IDLE);
    assign o_crc_done = (crc_state_r == CRC_DONE);

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_r <= `RST_ZERO32;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_ENERGY_POWER_ACCUM_CONFIG: rdata_r <= {16'h0000, energy_power_accum_config_r};
                `ADDR_POWER_UPDATE_TIME: rdata_r <= {16'h0000, power_update_time_r};
                `ADDR_ENERGY_UPDATE_TIME: rdata_r <= {16'h0000, energy_update_time_r};
                `ADDR_TEMP_SENSOR_CONFIG: rdata_r <= {16'h0000, temp_cfg_r};
                `ADDR_TEMP_MEASURE_RESULT: rdata_r <= {16'h0000, i_temp_result};
                `ADDR_CURRENT_A_GAIN: rdata_r <= {16'h0000, ai_gain_r};
                `ADDR_CONFIG_LOCK: rdata_r <= {16'h0000, lock_r};
                `ADDR_AUTOCAL_FLAGS: rdata_r <= {16'h0000, autocal_flags};
                `ADDR_PQ_FLAGS: rdata_r <= {16'h0000, pq_flags};
                `ADDR_CHIP_ERR_FLAGS: rdata_r <= {16'h0000, chip_flags};
                `ADDR_SILICON_REV: rdata_r <= {16'h0000, SILICON_REV};
                `ADDR_BURST_AI_WAVE: rdata_r <= i_meas_ai_wave;
                `ADDR_BURST_AV_WAVE: rdata_r <= i_meas_av_wave;
                `ADDR_BURST_BI_WAVE: rdata_r <= i_meas_bi_wave;
                `ADDR_BURST_AI_RMS: rdata_r <= i_meas_ai_rms;
                `ADDR_BURST_BI_RMS: rdata_r <= i_meas_bi_rms;
                // Write-only and unmapped offsets read as zero
                default: rdata_r <= `RST_ZERO32;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_rd;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;

    // ****************************************
    // Checks
    // ****************************************
    sequence seq_force_quiet;
        force_wr ##1 (!crc_start) [*5];
    endsequence

    sequence seq_pass_done;
        o_crc_done && $past(o_crc_busy, 5);
    endsequence

    AST_AUTOCAL_SUMMARY: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_autocal_evt != 16'h0000) |=> o_tier1_summary[0])
        else $error("Autocal flags set without summary");

    AST_AUTOCAL_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
        (rd_autocal && i_autocal_evt == 16'h0000) |=>
        (autocal_flags == 16'h0000) && o_rvalid && (o_rdata[15:0] == $past(autocal_flags)))
        else $error("Autocal read did not return and clear");

    AST_AUTOCAL_KEEP_NEW: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_autocal |=> (autocal_flags == $past(i_autocal_evt)))
        else $error("Autocal flags after read differ from coincident events");

    AST_PQ_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_pq |=> (pq_flags == $past(i_pq_evt)) && (o_rdata[15:0] == $past(pq_flags)))
        else $error("Power-quality flags did not clear on read");

    AST_CHIP_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
        rd_chip |=> (chip_flags == $past(i_chip_evt)) && o_tier1_summary[2] == (|$past(i_chip_evt)))
        else $error("Chip-error flags did not clear on read");

    AST_BAUD_SELECT: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == `ADDR_SERIAL_RATE) |=> (o_fast_baud == ($past(i_wdata) == `FAST_BAUD_KEY)))
        else $error("Serial rate select wrong after write");

    AST_FORCE_PASS: assert property (@(posedge i_mclk) disable iff (i_rst)
        seq_force_quiet |=> seq_pass_done)
        else $error("Forced checksum pass did not run");

    AST_LOCK_HOLDS: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_config_locked && i_wr && i_addr != `ADDR_CONFIG_LOCK) |=>
        $stable(o_energy_power_accum_config) && $stable(o_power_update_time) && $stable(o_energy_update_time)
        && $stable(o_temp_sensor_config) && $stable(o_current_a_gain_select))
        else $error("Locked configuration register changed");

    AST_BURST_MIRROR: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == `ADDR_BURST_AI_WAVE) |=> (o_rdata == $past(i_meas_ai_wave)))
        else $error("Burst mirror value wrong");

    AST_UPDATE_TIME_RESET: assert property (@(posedge i_mclk)
        (!i_rst && $past(i_rst)) |->
        (o_power_update_time == `RST_UPDATE_TIME) && (o_energy_update_time == `RST_UPDATE_TIME))
        else $error("Update time reset value wrong");

    AST_WO_READS_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_rd && (i_addr == `ADDR_SERIAL_RATE || i_addr == `ADDR_CHECKSUM_TRIGGER)) |=> (o_rdata == `RST_ZERO32))
        else $error("Write-only register read nonzero");

endmodule : metering_config_status_regs

// *** tb/host_port_model.sv ***
/*
 * Host side of the register port: issues one-cycle read and write strobes.
 * Assumes the bank answers a read with o_rvalid one cycle after the strobe.
 */
`timescale 1ns/1ps
module host_port_model (
    input wire logic i_mclk,
    input wire logic i_rvalid,
    input wire logic [31:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [11:0] o_addr,
    output logic [15:0] o_wdata
);
    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 12'h000;
        o_wdata = 16'h0000;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    // Released lines show inverted data, so a stale value never passes for a fresh one
    task automatic write_reg(input logic [11:0] addr, input logic [15:0] data);
        @(posedge i_mclk);
        #1;
        o_wr = 1'b1;
        o_addr = addr;
        o_wdata = data;
        @(posedge i_mclk);
        #1;
        o_wr = 1'b0;
        o_addr = ~addr;
        o_wdata = ~data;
    endtask : write_reg

    task automatic read_reg(input logic [11:0] addr, output logic [31:0] data, output logic ok);
        int n;
        @(posedge i_mclk);
        #1;
        o_rd = 1'b1;
        o_addr = addr;
        @(posedge i_mclk);
        #1;
        o_rd = 1'b0;
        o_addr = ~addr;
        ok = 1'b0;
        data = 32'h0000_0000;
        for (n = 0; n < 3 && !ok; n++) begin
            if (i_rvalid === 1'b1) begin
                data = i_rdata;
                ok = (n == 0);
            end else begin
                @(posedge i_mclk);
                #1;
            end
        end
    endtask : read_reg
endmodule : host_port_model

// *** tb/metering_config_status_regs_tb.sv ***
/*
 * Self-checking bench of the metering configuration and status bank.
 * Assumes the host model drives the port; events and measurements come from here.
 */
`timescale 1ns/1ps
`include "metering_regs_map.svh"
module metering_config_status_regs_tb;
    import metering_regs_pkg::*;
    localparam logic [15:0] REV = 16'h3c21; // Arbitrary value
    logic i_mclk = 1'b0, i_rst = 1'b1, i_wr, i_rd, o_rvalid, o_config_locked, o_fast_baud, o_crc_busy, o_crc_done;
    logic [11:0] i_addr;
    logic [15:0] i_wdata, o_crc_result, o_power_update_time, o_energy_power_accum_config;
    logic [15:0] o_energy_update_time, o_temp_sensor_config, o_current_a_gain_select;
    logic [15:0] i_autocal_evt = 16'h0000, i_pq_evt = 16'h0000, i_chip_evt = 16'h0000, i_temp_result = 16'h1357;
    logic [31:0] meas [5] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004, 32'h5555_0005};
    logic [31:0] o_rdata;
    logic [2:0] o_tier1_summary;
    logic [11:0] burst_a [5] = '{12'h600, 12'h601, 12'h602, 12'h604, 12'h605};
    logic [11:0] rst_a [13] = '{12'h4b0, 12'h4b1, 12'h4b2, 12'h4b4, 12'h4b6, 12'h4b7, 12'h4b9, 12'h4bf,
                                12'h4c0, 12'h4c1, 12'h4c2, 12'h4dc, 12'h4fe};
    logic [15:0] rst_v [13] = '{16'h0000, 16'h00ff, 16'h00ff, 16'h0000, 16'h0000, 16'h1357, 16'h0000, 16'h0000,
                                16'h0000, 16'h0000, 16'h0000, 16'h0000, REV};
    logic [11:0] cfg_a [5] = '{12'h4b0, 12'h4b1, 12'h4b2, 12'h4b6, 12'h4b9};
    logic [15:0] cfg_v [5] = '{16'ha1b2, 16'h0001, 16'hffff, 16'h00c3, 16'h0007};
    int bad_count = 0, checks = 0, cycles = 0;

    // ****************************************
    // Clock, harness and timeout
    // ****************************************
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end

    host_port_model host (.i_mclk(i_mclk), .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
        .o_addr(i_addr), .o_wdata(i_wdata));

    // Refresh period beyond the run, so each checksum pass is one the bench started
    metering_config_status_regs #(.CRC_REFRESH_CYCLES(4096), .SILICON_REV(REV)) DUT (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_autocal_evt(i_autocal_evt), .i_pq_evt(i_pq_evt), .i_chip_evt(i_chip_evt),
        .i_temp_result(i_temp_result), .i_meas_ai_wave(meas[0]), .i_meas_av_wave(meas[1]),
        .i_meas_bi_wave(meas[2]), .i_meas_ai_rms(meas[3]), .i_meas_bi_rms(meas[4]), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_energy_power_accum_config(o_energy_power_accum_config),
        .o_power_update_time(o_power_update_time), .o_energy_update_time(o_energy_update_time),
        .o_temp_sensor_config(o_temp_sensor_config), .o_current_a_gain_select(o_current_a_gain_select),
        .o_config_locked(o_config_locked), .o_tier1_summary(o_tier1_summary), .o_fast_baud(o_fast_baud),
        .o_crc_result(o_crc_result), .o_crc_busy(o_crc_busy), .o_crc_done(o_crc_done));

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        host.read_reg(addr, d, ok);
        check({name, " answer"}, {31'h0, ok}, 32'h1);
        check(name, d, exp);
    endtask : rd_chk

    task automatic set_evt(input int k, input logic [15:0] v);
        case (k)
            0: i_autocal_evt = v;
            1: i_pq_evt = v;
            default: i_chip_evt = v;
        endcase
    endtask : set_evt

    function automatic logic [15:0] crc_ref();
        logic [15:0] c;
        c = `CRC_INIT;
        for (int w = 0; w < 5; w++) begin
            for (int b = 15; b >= 0; b--) begin
                c = (c[15] ^ cfg_v[w][b]) ? ({c[14:0], 1'b0} ^ `CRC_POLY) : {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_ref

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        int n;
        repeat (10) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        for (int i = 0; i < 13; i++) rd_chk("reset value", rst_a[i], {16'h0, rst_v[i]});
        check("rate after reset", o_fast_baud, 1'b0);
        check("power time out", o_power_update_time, 16'h00ff);
        check("energy time out", o_energy_update_time, 16'h00ff);
        $display("test reset done");

        for (int i = 0; i < 5; i++) host.write_reg(cfg_a[i], cfg_v[i]);
        for (int i = 0; i < 5; i++) rd_chk("config readback", cfg_a[i], {16'h0, cfg_v[i]});
        check("accum cfg out", o_energy_power_accum_config, cfg_v[0]);
        check("energy time cfg out", o_energy_update_time, cfg_v[2]);
        check("temp cfg out", o_temp_sensor_config, cfg_v[3]);
        check("gain cfg out", o_current_a_gain_select, cfg_v[4]);
        host.write_reg(12'h4b7, 16'hdead);
        rd_chk("read-only result", 12'h4b7, 32'h0000_1357);
        host.write_reg(12'h4fe, 16'hbeef);
        rd_chk("read-only revision", 12'h4fe, {16'h0, REV});
        rd_chk("trigger reads zero", 12'h4b4, 32'h0);
        rd_chk("unmapped", 12'h603, 32'h0);
        $display("test access done");

        host.write_reg(12'h4bf, 16'h0001);
        check("lock level", o_config_locked, 1'b1);
        host.write_reg(12'h4b1, 16'h5555);
        rd_chk("locked write", 12'h4b1, 32'h0000_0001);
        check("locked output", o_power_update_time, 16'h0001);
        host.write_reg(12'h4bf, 16'h0000);
        host.write_reg(12'h4b1, 16'h5555);
        cfg_v[1] = 16'h5555;
        rd_chk("unlocked write", 12'h4b1, 32'h0000_5555);
        $display("test lock done");

        host.write_reg(12'h4dc, 16'h0052);
        check("fast rate", o_fast_baud, 1'b1);
        rd_chk("rate select reads zero", 12'h4dc, 32'h0);
        host.write_reg(12'h4dc, 16'h0053);
        check("near key", o_fast_baud, 1'b0);
        host.write_reg(12'h4dc, 16'h0052);
        host.write_reg(12'h4dc, 16'h0000);
        check("slow rate", o_fast_baud, 1'b0);
        $display("test rate done");

        host.write_reg(12'h4b4, 16'h0001);
        check("pass busy", o_crc_busy, 1'b1);
        for (n = 0; n < 10 && o_crc_done !== 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
        end
        check("pass length", n, 5);
        check("checksum", o_crc_result, crc_ref());
        $display("test checksum done");

        for (int k = 0; k < 3; k++) begin
            @(posedge i_mclk);
            #1;
            set_evt(k, 16'h0a05);
            @(posedge i_mclk);
            #1;
            set_evt(k, 16'h0000);
            check("summary set", o_tier1_summary, 3'h1 << k);
            rd_chk("flags", 12'h4c0 + 12'(k), 32'h0000_0a05);
            check("summary cleared", o_tier1_summary, 3'h0);
            fork
                rd_chk("flags empty", 12'h4c0 + 12'(k), 32'h0);
                begin
                    @(posedge i_mclk);
                    #1;
                    set_evt(k, 16'h8000);
                    @(posedge i_mclk);
                    #1;
                    set_evt(k, 16'h0000);
                end
            join
            check("summary kept", o_tier1_summary, 3'h1 << k);
            rd_chk("coincident event", 12'h4c0 + 12'(k), 32'h0000_8000);
            rd_chk("flags cleared", 12'h4c0 + 12'(k), 32'h0);
        end
        $display("test status done");

        for (int i = 0; i < 5; i++) rd_chk("burst mirror", burst_a[i], meas[i]);
        @(posedge i_mclk);
        #1;
        meas[0] = 32'h8765_4321;
        meas[4] = 32'hfedc_ba98;
        rd_chk("live mirror", 12'h600, 32'h8765_4321);
        rd_chk("live rms mirror", 12'h605, 32'hfedc_ba98);
        $display("test burst done");
        final_report();
    end
endmodule : metering_config_status_regs_tb
